/* File: rtl/adc_trig_cal_defs.svh */
// offsets, field positions, reset values and timing counts for the trigger/calibration block
// assumes a 12-bit APB byte address and a 250 MHz ref_clk
`ifndef ADC_TRIG_CAL_DEFS_SVH
`define ADC_TRIG_CAL_DEFS_SVH

`define APB_ADDR_W 12
`define TRIG_SEL_BASE 12'h000
`define TRIG_SEL_COUNT 3'd6
`define CORE_CAL_LOW_ADDR 12'h018
`define CORE_CAL_HIGH_ADDR 12'h01c
`define CORE_COUNT 4
`define CHANNEL_COUNT 12

`define TRIG_FIELD_W 5
`define TRIG_HI_LSB 8
`define TRIG_LO_LSB 0
`define TRIG_CODE_NONE 5'h00
`define TRIG_CODE_RESERVED 5'h03

`define CAL_RDY_BIT 7
`define CAL_BYPASS_BIT 3
`define CAL_DIFF_BIT 2
`define CAL_EN_BIT 1
`define CAL_START_BIT 0

`define REG_RESET 16'h0000
`define RD_IDLE 32'h0000_0000

`define CLK_PERIOD_PS 4000
`define CAL_TIME_NS 1000
`define PWRUP_WAIT_NS 400
// least times: round up to whole cycles
`define CAL_CYCLES ((`CAL_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PWRUP_CYCLES ((`PWRUP_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* File: rtl/adc_trig_cal_pkg.sv */
// types shared by the trigger-select and core calibration logic
// assumes nothing of its surroundings
package adc_trig_cal_pkg;
    typedef logic [4:0] trig_code_t;
    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_IDLE = 3'b010,
        ST_CAL  = 3'b100
    } cal_state_t;
endpackage

/* File: rtl/adc_trig_cal_top.sv */
// trigger source selection for channels 4x+2/4x+3 and dedicated core calibration control
// assumes an APB master on ref_clk and trigger sources synchronous to ref_clk
//
// Functional notes
// - six select registers: bits 12-8 pick channel 4x+3, bits 4-0 channel 4x+2
// - code 0 no trigger, 1 common software, 2 level software, 3 reserved
// - code 4 special event, codes 5-10 primary triggers of generators 1-6
// - code 12 timer 1, 13 timer 2, 14 secondary special event
// - codes 15-20 secondary triggers of generators 1-6
// - codes 22/23 output compare 1/2, codes 11/21 logic cells one/two
// - codes 24-29 current-limit triggers of generators 1-6
// - code 30 trigger generator output 30, code 31 external pin
// - one calibration byte per core: cores 0/1 low register, 2/3 high
// - ready flag low during calibration, high once finished
// - bypass set skips power-up calibration, clear calibrates after power-up
// - differential bit picks differential or single-ended calibration
// - enable bit clear hides ready, bypass, differential and start bits
// - writing start launches calibration, hardware clears start afterwards
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "adc_trig_cal_defs.svh"
module adc_trig_cal_top
    import adc_trig_cal_pkg::*;
#(
    parameter int ADDR_W = `APB_ADDR_W,
    parameter int CAL_CYCLES = `CAL_CYCLES,
    parameter int PWRUP_CYCLES = `PWRUP_CYCLES
) (
    input wire logic ref_clk, // system clock, 250 MHz
    input wire logic rst_b, // sync reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic sw_common_trig, // common software trigger
    input wire logic sw_level_trig, // level software trigger
    input wire logic pwm_special_event, // pwm special event trigger
    input wire logic [5:0] pwm_primary_trig, // primary trigger, generators 1-6
    input wire logic logic_cell_one_output, // logic cell one
    input wire logic timer1_period_match, // timer 1 period match
    input wire logic timer2_period_match, // timer 2 period match
    input wire logic pwm_secondary_special_event, // secondary special event
    input wire logic [5:0] pwm_secondary_trig, // secondary trigger, generators 1-6
    input wire logic logic_cell_two_output, // logic cell two
    input wire logic out_compare1_trig, // output compare 1
    input wire logic out_compare2_trig, // output compare 2
    input wire logic [5:0] pwm_current_limit_trig, // current limit, generators 1-6
    input wire logic peripheral_trigger_generator_out30, // trigger generator output 30
    input wire logic external_conv_trigger_pin, // external trigger pin
    output logic [11:0] conv_trigger, // [2x] channel 4x+2, [2x+1] channel 4x+3
    output logic [3:0] core_cal_active, // per core calibration running
    output logic [3:0] core_cal_diff_mode // per core calibration input mode
);
    localparam int CH = `CHANNEL_COUNT;
    localparam int CORES = `CORE_COUNT;

    trig_code_t trig_sel [CH];
    logic [31:0] src;
    logic [31:0] rd_word;
    logic hit_trig, hit_cal_lo, hit_cal_hi, mapped;
    logic setup, wr_go;
    logic [3:0] rd_lo_i, rd_hi_i;
    logic [CORES-1:0] core_wr;
    logic [7:0] core_rbyte [CORES];
    logic trig_q [CH];

    // source vector indexed by select code; 0 and 3 tied low
    assign src = {
        external_conv_trigger_pin,
        peripheral_trigger_generator_out30,
        pwm_current_limit_trig,
        out_compare2_trig,
        out_compare1_trig,
        logic_cell_two_output,
        pwm_secondary_trig,
        pwm_secondary_special_event,
        timer2_period_match,
        timer1_period_match,
        logic_cell_one_output,
        pwm_primary_trig,
        pwm_special_event,
        1'b0,
        sw_level_trig,
        sw_common_trig,
        1'b0
    };

    // address decode
    always_comb begin
        hit_trig = 1'b0;
        hit_cal_lo = 1'b0;
        hit_cal_hi = 1'b0;
        if (paddr[1:0] == 2'b00 && paddr[ADDR_W-1:5] == '0 && paddr[4:2] < `TRIG_SEL_COUNT) begin
            hit_trig = 1'b1;
        end else if (paddr == `CORE_CAL_LOW_ADDR) begin
            hit_cal_lo = 1'b1;
        end else if (paddr == `CORE_CAL_HIGH_ADDR) begin
            hit_cal_hi = 1'b1;
        end
    end

    assign mapped = hit_trig | hit_cal_lo | hit_cal_hi;
    assign setup = psel && !penable;
    // no wait state: data and ready are registered in the setup cycle
    assign wr_go = psel && penable && pready && pwrite && mapped;
    assign rd_lo_i = {paddr[4:2], 1'b0};
    assign rd_hi_i = {paddr[4:2], 1'b1};

    always_comb begin
        rd_word = `RD_IDLE;
        if (hit_trig) begin
            rd_word[`TRIG_HI_LSB +: `TRIG_FIELD_W] = trig_sel[rd_hi_i];
            rd_word[`TRIG_LO_LSB +: `TRIG_FIELD_W] = trig_sel[rd_lo_i];
        end else if (hit_cal_lo) begin
            rd_word[15:0] = {core_rbyte[1], core_rbyte[0]};
        end else if (hit_cal_hi) begin
            rd_word[15:0] = {core_rbyte[3], core_rbyte[2]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `RD_IDLE;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= !mapped;
                prdata <= pwrite ? `RD_IDLE : rd_word;
            end else begin
                pslverr <= 1'b0;
                prdata <= `RD_IDLE;
            end
        end
    end

    // select registers: even entry is channel 4x+2, odd entry channel 4x+3
    for (genvar x = 0; x < CH / 2; x++) begin : g_sel
        always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
                trig_sel[2*x] <= `TRIG_CODE_NONE;
                trig_sel[2*x+1] <= `TRIG_CODE_NONE;
            end else if (wr_go && hit_trig && paddr[4:2] == 3'(x)) begin
                if (pstrb[0]) trig_sel[2*x] <= pwdata[`TRIG_LO_LSB +: `TRIG_FIELD_W];
                if (pstrb[1]) trig_sel[2*x+1] <= pwdata[`TRIG_HI_LSB +: `TRIG_FIELD_W];
            end
        end
    end

    // registered so each channel sees a glitch-free one-cycle-late trigger
    for (genvar j = 0; j < CH; j++) begin : g_trig
        always_ff @(posedge ref_clk) begin
            if (!rst_b) trig_q[j] <= 1'b0;
            else trig_q[j] <= src[trig_sel[j]];
        end
        assign conv_trigger[j] = trig_q[j];
    end

    for (genvar k = 0; k < CORES; k++) begin : g_core
        localparam int LANE = k % 2;
        assign core_wr[k] = wr_go && ((k < 2) ? hit_cal_lo : hit_cal_hi) && pstrb[LANE];
        core_cal_ctrl #(
            .CAL_CYCLES(CAL_CYCLES),
            .PWRUP_CYCLES(PWRUP_CYCLES)
        ) u_core (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .wr(core_wr[k]),
            .wbyte(pwdata[8*LANE +: 8]),
            .rbyte(core_rbyte[k]),
            .cal_active(core_cal_active[k]),
            .cal_diff_mode(core_cal_diff_mode[k])
        );
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_trig_write;
        wr_go && hit_trig && paddr[4:2] == 3'd0 && pstrb[1:0] == 2'b11
            |=> trig_sel[0] == $past(pwdata[4:0]) && trig_sel[1] == $past(pwdata[12:8]);
    endproperty
    a_trig_write: assert property (p_trig_write) else $error("select write lost");
    property p_no_trig;
        trig_sel[0] == `TRIG_CODE_NONE || trig_sel[0] == `TRIG_CODE_RESERVED
            |=> !conv_trigger[0];
    endproperty
    a_no_trig: assert property (p_no_trig) else $error("idle code triggered");
    property p_common;
        trig_sel[1] == 5'h01 |=> conv_trigger[1] == $past(sw_common_trig);
    endproperty
    a_common: assert property (p_common) else $error("common sw trigger wrong");
    property p_primary6;
        trig_sel[2] == 5'h0a |=> conv_trigger[2] == $past(pwm_primary_trig[5]);
    endproperty
    a_primary6: assert property (p_primary6) else $error("primary 6 wrong");
    property p_timer1;
        trig_sel[3] == 5'h0c |=> conv_trigger[3] == $past(timer1_period_match);
    endproperty
    a_timer1: assert property (p_timer1) else $error("timer1 wrong");
    property p_secondary1;
        trig_sel[4] == 5'h0f |=> conv_trigger[4] == $past(pwm_secondary_trig[0]);
    endproperty
    a_secondary1: assert property (p_secondary1) else $error("secondary 1 wrong");
    property p_oc2;
        trig_sel[5] == 5'h17 |=> conv_trigger[5] == $past(out_compare2_trig);
    endproperty
    a_oc2: assert property (p_oc2) else $error("compare 2 wrong");
    property p_limit6;
        trig_sel[11] == 5'h1d |=> conv_trigger[11] == $past(pwm_current_limit_trig[5]);
    endproperty
    a_limit6: assert property (p_limit6) else $error("current limit 6 wrong");
    property p_ext;
        trig_sel[10] == 5'h1f |=> conv_trigger[10] == $past(external_conv_trigger_pin);
    endproperty
    a_ext: assert property (p_ext) else $error("external pin wrong");
    property p_cal_map;
        setup && !pwrite && hit_cal_hi
            |=> prdata[15:8] == $past(core_rbyte[3]) && prdata[7:0] == $past(core_rbyte[2]);
    endproperty
    a_cal_map: assert property (p_cal_map) else $error("calibration byte map");
    property p_unimpl_zero;
        pready |-> prdata[31:16] == 16'h0000 && (!$past(hit_trig)
            || (prdata[15:13] == 3'b000 && prdata[7:5] == 3'b000));
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits set");
    property p_unmapped;
        setup && !mapped |=> pready && pslverr && prdata == `RD_IDLE ##1 !pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped answer");
    c_trig_fire: cover property (trig_sel[0] != `TRIG_CODE_NONE ##1 conv_trigger[0]);
    c_cal_start: cover property (wr_go && hit_cal_lo && pwdata[`CAL_START_BIT]);
    c_slverr: cover property (pslverr);
endmodule

/* File: rtl/core_cal_ctrl.sv */
// calibration control group of one dedicated converter core (one register byte)
// assumes wr is a one-cycle APB write strobe for this byte lane
`timescale 1ns/1ps
`include "adc_trig_cal_defs.svh"
module core_cal_ctrl
    import adc_trig_cal_pkg::*;
#(
    parameter int CAL_CYCLES = `CAL_CYCLES,
    parameter int PWRUP_CYCLES = `PWRUP_CYCLES
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic wr, // write strobe for this byte
    input wire logic [7:0] wbyte, // write data byte
    output logic [7:0] rbyte, // read view of this byte
    output logic cal_active, // core is calibrating
    output logic cal_diff_mode // mode of the running calibration
);
    cal_state_t state, next_state;
    logic [15:0] cnt;
    logic en, bypass, diff, start, ready;
    logic wait_end, cal_end, start_ok;

    assign wait_end = (state == ST_WAIT) && (cnt == 16'(PWRUP_CYCLES - 1));
    assign cal_end = (state == ST_CAL) && (cnt == 16'(CAL_CYCLES - 1));
    assign start_ok = wr && en && wbyte[`CAL_START_BIT];

    always_comb begin
        next_state = state;
        case (state)
            ST_WAIT: if (wait_end) next_state = bypass ? ST_IDLE : ST_CAL;
            ST_IDLE: if (start) next_state = ST_CAL;
            ST_CAL: if (cal_end) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= ST_WAIT;
            cnt <= 16'h0000;
        end else begin
            state <= next_state;
            if (next_state != state || state == ST_IDLE) cnt <= 16'h0000;
            else cnt <= cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ready <= 1'b0;
            cal_active <= 1'b0;
            cal_diff_mode <= 1'b0;
        end else begin
            cal_active <= (next_state == ST_CAL);
            if (next_state == ST_CAL) ready <= 1'b0;
            else if (next_state == ST_IDLE) ready <= 1'b1;
            // mode is frozen for the whole run
            if (next_state == ST_CAL && state != ST_CAL) cal_diff_mode <= diff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            en <= 1'b0;
            bypass <= 1'b0;
            diff <= 1'b0;
        end else begin
            if (wr) en <= wbyte[`CAL_EN_BIT];
            // gated by the enable already held, not the one in the same write
            if (wr && en) begin
                bypass <= wbyte[`CAL_BYPASS_BIT];
                diff <= wbyte[`CAL_DIFF_BIT];
            end
        end
    end

    // set beats the hardware clear so a start written at acceptance is not lost
    always_ff @(posedge ref_clk) begin
        if (!rst_b) start <= 1'b0;
        else if (start_ok) start <= 1'b1;
        else if (state == ST_IDLE && start) start <= 1'b0;
    end

    assign rbyte = {en & ready, 3'b000, en & bypass, en & diff, en, en & start};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_rdy_low_in_cal;
        cal_active |-> !ready;
    endproperty
    a_rdy_low_in_cal: assert property (p_rdy_low_in_cal) else $error("ready high in cal");
    property p_rdy_after_cal;
        $fell(cal_active) |-> ready;
    endproperty
    a_rdy_after_cal: assert property (p_rdy_after_cal) else $error("ready not set");
    // a start pending at the end of the wait launches a run right after the skip
    property p_bypass_skip;
        wait_end && bypass && !start && !start_ok |=> !cal_active ##1 !cal_active && ready;
    endproperty
    a_bypass_skip: assert property (p_bypass_skip) else $error("bypass ignored");
    property p_start_clears;
        start && state == ST_IDLE && !start_ok |=> cal_active && !start;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start not taken");
    property p_gated_write;
        wr && !en |=> $stable(bypass) && $stable(diff) && !$rose(start);
    endproperty
    a_gated_write: assert property (p_gated_write) else $error("write not gated");
    property p_gated_read;
        !en |-> rbyte == 8'h00;
    endproperty
    a_gated_read: assert property (p_gated_read) else $error("read not gated");
    c_cal_done: cover property ($fell(cal_active));
    c_skip: cover property (wait_end && bypass);
endmodule

/* File: verif/adc_trig_cal_bench.sv */
// self-checking bench for the trigger select and dedicated core calibration block
// assumes pready within a bounded number of access cycles; short calibration counts
`timescale 1ns/1ps
`include "adc_trig_cal_defs.svh"
module adc_trigger_select_and_core_calibration_bench
    import adc_trig_cal_pkg::*;
;
    localparam int CAL = 8;
    localparam int PW = 12; // long enough to write enable then bypass before the wait ends
    logic ref_clk;
    logic rst_b;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] src; // bit n is the source that select code n names
    logic [11:0] conv_trigger;
    logic [3:0] core_cal_active;
    logic [3:0] core_cal_diff_mode;
    logic [31:0] rdat;
    logic rerr;
    logic [31:0] d;
    int n_mismatch;
    int n_checks;
    int c;
    int x;
    int s;

    adc_trig_cal_top #(.ADDR_W(12), .CAL_CYCLES(CAL), .PWRUP_CYCLES(PW)) u_adc_trig_cal_top (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sw_common_trig(src[1]), .sw_level_trig(src[2]),
        .pwm_special_event(src[4]), .pwm_primary_trig(src[10:5]),
        .logic_cell_one_output(src[11]), .timer1_period_match(src[12]),
        .timer2_period_match(src[13]), .pwm_secondary_special_event(src[14]),
        .pwm_secondary_trig(src[20:15]), .logic_cell_two_output(src[21]),
        .out_compare1_trig(src[22]), .out_compare2_trig(src[23]),
        .pwm_current_limit_trig(src[29:24]), .peripheral_trigger_generator_out30(src[30]),
        .external_conv_trigger_pin(src[31]), .conv_trigger(conv_trigger),
        .core_cal_active(core_cal_active), .core_cal_diff_mode(core_cal_diff_mode)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        n_mismatch++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) fail($sformatf("read got %h want %h", got, exp));
    endtask

    task automatic chk_sig(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) fail($sformatf("output got %h want %h", got, exp));
    endtask

    // request held from setup until the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] st);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i < 20) begin
            rdat = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end else begin
            fail("no pready");
            test_done();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
        apb(1'b1, a, wd, st);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk_word(rdat, exp);
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
    endtask

    function automatic logic [11:0] exp_trig(input int cc, input int ss);
        logic [11:0] e;
        int code;
        e = 12'h000;
        for (int j = 0; j < 12; j++) begin
            code = (cc + j) % 32;
            e[j] = (code == ss) && (code != 0) && (code != 3);
        end
        return e;
    endfunction

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        src = 32'h0000_0000;
        n_mismatch = 0;
        n_checks = 0;
        do_reset();
        repeat (PW - 2) @(posedge ref_clk);
        #1;
        chk_sig({8'h00, core_cal_active}, 12'h000);
        repeat (4) @(posedge ref_clk);
        #1;
        chk_sig({8'h00, core_cal_active}, 12'h00f);
        repeat (CAL + 8) @(posedge ref_clk);
        #1;
        chk_sig({8'h00, core_cal_active}, 12'h000);
        for (x = 0; x < 8; x++) rd(12'(4 * x), 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0000_0000, 4'h0);
        chk_sig({11'h000, rerr}, 12'h001);
        chk_word(rdat, 32'h0000_0000);
        apb(1'b1, 12'h024, 32'hffff_ffff, 4'hf);
        chk_sig({11'h000, rerr}, 12'h001);
        $display("test reset_and_map done");
        // every channel sees every code, each source pulsed alone
        for (c = 0; c < 32; c++) begin
            for (x = 0; x < 6; x++) begin
                d = {19'h0, trig_code_t'((c + 2 * x + 1) % 32), 3'h0,
                     trig_code_t'((c + 2 * x) % 32)};
                wr(`TRIG_SEL_BASE + 12'(4 * x), d, 4'h3);
            end
            for (s = 0; s < 32; s++) begin
                @(posedge ref_clk);
                src <= 32'h1 << s;
                repeat (2) @(posedge ref_clk);
                #1;
                chk_sig(conv_trigger, exp_trig(c, s));
            end
        end
        @(posedge ref_clk);
        src <= 32'h0000_0000;
        $display("test trigger_codes done");
        wr(`TRIG_SEL_BASE, 32'hffff_ffff, 4'h3);
        rd(`TRIG_SEL_BASE, 32'h0000_1f1f);
        wr(`TRIG_SEL_BASE, 32'h0000_0005, 4'h1);
        rd(`TRIG_SEL_BASE, 32'h0000_1f05);
        $display("test field_masks done");
        do_reset();
        wr(`CORE_CAL_LOW_ADDR, 32'h0000_0202, 4'h3);
        wr(`CORE_CAL_LOW_ADDR, 32'h0000_020a, 4'h3);
        repeat (9) @(posedge ref_clk);
        #1;
        chk_sig({8'h00, core_cal_active}, 12'h00e);
        rd(`CORE_CAL_LOW_ADDR, 32'h0000_028a);
        repeat (CAL + 4) @(posedge ref_clk);
        rd(`CORE_CAL_LOW_ADDR, 32'h0000_828a);
        wr(`CORE_CAL_LOW_ADDR, 32'h0000_0700, 4'h2);
        repeat (2) @(posedge ref_clk);
        #1;
        chk_sig({8'h00, core_cal_active}, 12'h002);
        chk_sig({8'h00, core_cal_diff_mode}, 12'h002);
        rd(`CORE_CAL_LOW_ADDR, 32'h0000_068a);
        repeat (CAL + 4) @(posedge ref_clk);
        rd(`CORE_CAL_LOW_ADDR, 32'h0000_868a);
        wr(`CORE_CAL_HIGH_ADDR, 32'h0000_000d, 4'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        chk_sig({8'h00, core_cal_active}, 12'h000);
        rd(`CORE_CAL_HIGH_ADDR, 32'h0000_0000);
        wr(`CORE_CAL_HIGH_ADDR, 32'h0000_0200, 4'h2);
        rd(`CORE_CAL_HIGH_ADDR, 32'h0000_8200);
        wr(`CORE_CAL_HIGH_ADDR, 32'h0000_f600, 4'h2);
        rd(`CORE_CAL_HIGH_ADDR, 32'h0000_8600);
        rd(`TRIG_SEL_BASE, 32'h0000_0000);
        $display("test calibration done");
        test_done();
    end
endmodule
